// [design/sltc_defs.vh]
// constants for the scan line timing core
`ifndef SLTC_DEFS_VH
`define SLTC_DEFS_VH
`define SLTC_CTRL_SOFT_RESET_BIT 5
`define SLTC_CTRL_SCAN_VAL 8'h03
`define SLTC_CTRL_IDLE_VAL 8'h00
`define SLTC_MCLK_CODE_W 6
`define SLTC_MCLK_CODE_MAX 6'h3f
`define SLTC_PIX_W 14
`define SLTC_GAIN_W 16
`define SLTC_GAIN_SHIFT 14
`define SLTC_LINE_W 14
`define SLTC_LINE_MAX 14'h3fff
`define SLTC_ADDR_W 14
`define SLTC_ADDR_MAX 14'h3fff
`define SLTC_ADDR_LEGAL_RST 14'h3fff
`define SLTC_PHASE_W 5
`define SLTC_PIXRATE_PHASES 5'h18
`define SLTC_LINERATE_PHASES 5'h08
`define SLTC_STRETCH_W 4
`define SLTC_FILL_W 8
`define SLTC_HDIV_W 4
`define SLTC_STEP_W 8
`endif

// [design/sltc_clk_div.v]
// half-step core clock divider producing a one-cycle enable
`timescale 1ns/1ns
module sltc_clk_div (
  input wire clk_i,
  input wire reset_i,
  input wire [5:0] code_i,
  output reg tick_o
);
  // ratio = 1 + code/2, counted in half periods: 2 + code halves
  reg [7:0] acc_r;
  wire [7:0] period_half;
  assign period_half = {2'h0, code_i} + 8'h02;
  always @(posedge clk_i) begin
    if (reset_i) begin
      acc_r <= 8'h00;
      tick_o <= 1'b0;
    end else if (acc_r + 8'h02 >= period_half) begin
      acc_r <= acc_r + 8'h02 - period_half;
      tick_o <= 1'b1;
    end else begin
      acc_r <= acc_r + 8'h02;
      tick_o <= 1'b0;
    end
  end
endmodule

// [design/sltc_core.v]
// scan line timing core: sensor timing, dataport addressing, gain, fill
//
// What this block does
// - stretch setting zero turns fast/slow line pairs off
// - core divide ratio is one plus half code
// - divider codes 0..63, ratio 1.0..32.5
// - gain multiplies literally, zero gives zero
// - soft reset halts external memory refresh
// - soft reset is control bit 5
// - line end cuts reset and clamp pulses
// - address wraps after highest legal, and after 0x3fff
// - phase settings 0..23 or 0..7 by mode
// - may skip one fewer full step
// - reverse in line-rate colour halts red
// - fill counter survives scan start
// - lines up to 16384 pixels per colour
`timescale 1ns/1ns
`include "sltc_defs.vh"
module sltc_core (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] ctrl_i,
  input wire [5:0] mclk_code_i,
  input wire line_rate_mode_i,
  input wire [3:0] horizontal_resolution_divider_i,
  input wire [3:0] integration_time_stretch_i,
  input wire dual_sample_mode_i,
  input wire [4:0] rst_on_i,
  input wire [4:0] rst_off_i,
  input wire [4:0] cp1_on_i,
  input wire [4:0] cp1_off_i,
  input wire [4:0] cp2_on_i,
  input wire [4:0] cp2_off_i,
  input wire [4:0] ref_sample_i,
  input wire [4:0] sig_sample_i,
  input wire [13:0] line_end_i,
  input wire [13:0] data_start_i,
  input wire [13:0] data_end_i,
  input wire [13:0] stored_phase_difference_i,
  input wire [13:0] addr_load_val_i,
  input wire addr_load_i,
  input wire addr_step_i,
  input wire [13:0] addr_legal_max_i,
  input wire [13:0] pixel_i,
  input wire [15:0] gain_coef_i,
  input wire [7:0] scan_step_size_i,
  input wire [7:0] feed_step_size_i,
  input wire [7:0] skip_steps_i,
  input wire reverse_en_i,
  input wire line_read_i,
  output reg core_tick_o,
  output reg pixel_tick_o,
  output reg sensor_reset_pulse_o,
  output reg clamp_pulse_one_o,
  output reg clamp_pulse_two_o,
  output reg ref_sample_o,
  output reg sig_sample_o,
  output reg line_end_o,
  output reg data_valid_o,
  output reg [13:0] pixel_index_o,
  output reg [13:0] pixel_o,
  output reg [13:0] dataport_addr_o,
  output reg [7:0] fill_count_o,
  output reg [7:0] skip_left_o,
  output reg [1:0] colour_o,
  output reg halted_red_o,
  output reg refresh_en_o,
  output reg coef_write_ok_o
);
  wire soft_rst;
  wire scanning;
  wire ctick;
  reg [4:0] phase_r;
  reg [3:0] hdiv_r;
  reg [3:0] stretch_r;
  reg slow_r;
  reg [13:0] line_pos_r;
  wire [4:0] phase_last;
  wire [3:0] stretch_eff;
  wire pix_end;
  wire line_done;
  wire [29:0] prod;
  reg scanning_q_r;

  // control value 0x20 holds the core in soft reset
  assign soft_rst = reset_i | ctrl_i[`SLTC_CTRL_SOFT_RESET_BIT];
  assign scanning = (ctrl_i == `SLTC_CTRL_SCAN_VAL);

  sltc_clk_div u_div (
    .clk_i(clk_i),
    .reset_i(soft_rst),
    .code_i(mclk_code_i),
    .tick_o(ctick)
  );

  function [4:0] phase_top;
    input lr;
    begin
      phase_top = lr ? (`SLTC_LINERATE_PHASES - 5'h01) :
                       (`SLTC_PIXRATE_PHASES - 5'h01);
    end
  endfunction

  // pulse window test shared by reset and clamp pulses
  function in_win;
    input [4:0] ph;
    input [4:0] on;
    input [4:0] off;
    begin
      if (on <= off)
        in_win = (ph >= on) && (ph < off);
      else
        in_win = (ph >= on) || (ph < off);
    end
  endfunction

  // fast lines of a stretched pair are read out but not digitised
  function slow_r_fast_skip;
    input s;
    begin
      slow_r_fast_skip = (integration_time_stretch_i != 4'h0) & ~s;
    end
  endfunction

  assign phase_last = phase_top(line_rate_mode_i);
  // stretch of zero behaves as one
  assign stretch_eff = (integration_time_stretch_i == 4'h0) ? 4'h1 :
                       integration_time_stretch_i;
  assign pix_end = ctick && (phase_r == phase_last);
  assign line_done = pix_end && (line_pos_r >= line_end_i);
  // product kept only for visibility; no check is made on it
  assign prod = {24'h0, mclk_code_i} * 30'h1;

  // pixel phase counter; during stretched lines the pixel pace slows
  always @(posedge clk_i) begin
    if (soft_rst) begin
      phase_r <= 5'h00;
      stretch_r <= 4'h0;
    end else if (ctick) begin
      if (phase_r >= phase_last) begin
        if (slow_r && stretch_r < stretch_eff - 4'h1) begin
          stretch_r <= stretch_r + 4'h1;
        end else begin
          stretch_r <= 4'h0;
          phase_r <= 5'h00;
        end
      end else begin
        phase_r <= phase_r + 5'h01;
      end
    end
  end

  wire pix_adv;
  assign pix_adv = pix_end && (!slow_r || stretch_r >= stretch_eff - 4'h1);

  // line position; alternating fast/slow lines when stretch is on
  always @(posedge clk_i) begin
    if (soft_rst) begin
      line_pos_r <= 14'h0000;
      slow_r <= 1'b0;
      hdiv_r <= 4'h0;
    end else if (pix_adv) begin
      if (line_pos_r >= line_end_i || line_pos_r == `SLTC_LINE_MAX) begin
        line_pos_r <= 14'h0000;
        slow_r <= (integration_time_stretch_i != 4'h0) & ~slow_r;
        hdiv_r <= 4'h0;
      end else begin
        line_pos_r <= line_pos_r + 14'h0001;
        if (hdiv_r + 4'h1 >= horizontal_resolution_divider_i)
          hdiv_r <= 4'h0;
        else
          hdiv_r <= hdiv_r + 4'h1;
      end
    end
  end

  wire in_data;
  wire lend;
  assign in_data = (line_pos_r >= data_start_i) &&
                   (line_pos_r < data_end_i);
  assign lend = pix_adv && (line_pos_r >= line_end_i);

  // sensor pulses; line end forces them off regardless of window
  always @(posedge clk_i) begin
    if (soft_rst || lend) begin
      sensor_reset_pulse_o <= 1'b0;
      clamp_pulse_one_o <= 1'b0;
      clamp_pulse_two_o <= 1'b0;
      ref_sample_o <= 1'b0;
      sig_sample_o <= 1'b0;
    end else begin
      sensor_reset_pulse_o <= in_win(phase_r, rst_on_i, rst_off_i);
      clamp_pulse_one_o <= in_win(phase_r, cp1_on_i, cp1_off_i);
      clamp_pulse_two_o <= in_win(phase_r, cp2_on_i, cp2_off_i);
      ref_sample_o <= ctick && dual_sample_mode_i &&
                      (phase_r == ref_sample_i);
      sig_sample_o <= ctick && (phase_r == sig_sample_i);
    end
  end

  // pixel path: literal gain, code zero yields zero
  wire [29:0] gprod;
  assign gprod = pixel_i * gain_coef_i;
  always @(posedge clk_i) begin
    if (soft_rst) begin
      core_tick_o <= 1'b0;
      pixel_tick_o <= 1'b0;
      line_end_o <= 1'b0;
      data_valid_o <= 1'b0;
      pixel_index_o <= 14'h0000;
      pixel_o <= 14'h0000;
    end else begin
      core_tick_o <= ctick;
      pixel_tick_o <= pix_adv;
      line_end_o <= lend;
      data_valid_o <= pix_adv && in_data && !slow_r_fast_skip(slow_r) &&
                      (hdiv_r == 4'h0);
      pixel_index_o <= line_pos_r;
      if (gprod[29:`SLTC_GAIN_SHIFT] > 30'h3fff)
        pixel_o <= 14'h3fff;
      else
        pixel_o <= gprod[27:14];
    end
  end

  // dataport address: wrap from the legal top, or from 0x3fff when above it
  always @(posedge clk_i) begin
    if (reset_i) begin
      dataport_addr_o <= 14'h0000;
    end else if (addr_load_i) begin
      dataport_addr_o <= addr_load_val_i;
    end else if (addr_step_i) begin
      if (dataport_addr_o == addr_legal_max_i)
        dataport_addr_o <= 14'h0000;
      else
        dataport_addr_o <= dataport_addr_o + 14'h0001;
    end
  end

  // fill counter: only soft reset clears it, scan start leaves it
  always @(posedge clk_i) begin
    if (soft_rst) begin
      fill_count_o <= 8'h00;
    end else if (lend && !slow_r_fast_skip(slow_r) && !line_read_i) begin
      fill_count_o <= fill_count_o + 8'h01;
    end else if (line_read_i && !lend && fill_count_o != 8'h00) begin
      fill_count_o <= fill_count_o - 8'h01;
    end
  end

  // motor start skip, colour sequence, halt on red when reversing
  always @(posedge clk_i) begin
    if (soft_rst) begin
      scanning_q_r <= 1'b0;
      skip_left_o <= 8'h00;
      colour_o <= 2'h0;
      halted_red_o <= 1'b0;
    end else begin
      scanning_q_r <= scanning;
      if (scanning && !scanning_q_r) begin
        // first step is taken at start, so one fewer gets skipped
        skip_left_o <= (skip_steps_i == 8'h00) ? 8'h00 :
                       skip_steps_i - 8'h01;
        colour_o <= 2'h0;
        halted_red_o <= 1'b0;
      end else if (scanning) begin
        if (lend && skip_left_o != 8'h00)
          skip_left_o <= skip_left_o - 8'h01;
        if (lend && line_rate_mode_i)
          colour_o <= (colour_o == 2'h2) ? 2'h0 : colour_o + 2'h1;
      end else if (scanning_q_r) begin
        halted_red_o <= 1'b1;
        if (reverse_en_i && line_rate_mode_i)
          colour_o <= 2'h0;
      end
    end
  end

  // refresh stops under soft reset; writes allowed only when idle
  always @(posedge clk_i) begin
    if (reset_i) begin
      refresh_en_o <= 1'b0;
      coef_write_ok_o <= 1'b0;
    end else begin
      refresh_en_o <= ~ctrl_i[`SLTC_CTRL_SOFT_RESET_BIT];
      coef_write_ok_o <= (ctrl_i == `SLTC_CTRL_IDLE_VAL);
    end
  end

  wire unused_ok;
  assign unused_ok = ^{prod, scan_step_size_i, feed_step_size_i,
                       stored_phase_difference_i, line_done};
endmodule

// [verif/sltc_sensor_model.sv]
// flat-field line sensor model feeding the digitised pixel level
`timescale 1ns/1ns
module sltc_sensor_model (
  input wire clk_i,
  input wire reset_i,
  input wire [13:0] level_i,
  output reg [13:0] pixel_o
);
  // uniform illumination, so every pixel carries the same charge
  always @(posedge clk_i) begin
    if (reset_i)
      pixel_o <= 14'h0000;
    else
      pixel_o <= level_i;
  end
endmodule

// [verif/sltc_core_assertions.sv]
// port checker for the scan line timing core
`timescale 1ns/1ns
module sltc_core_checker (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] ctrl_i,
  input wire addr_load_i,
  input wire addr_step_i,
  input wire [13:0] addr_load_val_i,
  input wire [13:0] addr_legal_max_i,
  input wire [15:0] gain_coef_i,
  input wire line_rate_mode_i,
  input wire reverse_en_i,
  input wire line_end_o,
  input wire sensor_reset_pulse_o,
  input wire clamp_pulse_one_o,
  input wire clamp_pulse_two_o,
  input wire data_valid_o,
  input wire [13:0] pixel_o,
  input wire [13:0] dataport_addr_o,
  input wire [7:0] fill_count_o,
  input wire [1:0] colour_o,
  input wire halted_red_o,
  input wire refresh_en_o,
  input wire coef_write_ok_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire stp = addr_step_i && !addr_load_i;
  sequence pulses_low;
    !sensor_reset_pulse_o && !clamp_pulse_one_o && !clamp_pulse_two_o;
  endsequence
  addr_wrap_a: assert property (stp && dataport_addr_o == addr_legal_max_i
    |=> dataport_addr_o == 14'h0000) else $error("addr no wrap");
  addr_no_wrap_a: assert property (stp && dataport_addr_o > addr_legal_max_i
    && dataport_addr_o != 14'h3fff
    |=> dataport_addr_o == $past(dataport_addr_o) + 14'h0001)
    else $error("addr wrapped above max");
  addr_load_a: assert property (addr_load_i
    |=> dataport_addr_o == $past(addr_load_val_i)) else $error("bad load");
  line_cut_a: assert property (line_end_o |-> pulses_low)
    else $error("pulse alive at line end");
  refresh_stop_a: assert property (ctrl_i[5] |=> !refresh_en_o)
    else $error("refresh in soft reset");
  fill_clear_a: assert property (ctrl_i[5] |=> fill_count_o == 8'h00)
    else $error("fill not cleared");
  gain_zero_a: assert property (data_valid_o && gain_coef_i == 16'h0000 &&
    $past(gain_coef_i) == 16'h0000 |-> pixel_o == 14'h0000)
    else $error("zero gain passed pixel");
  red_halt_a: assert property ($rose(halted_red_o) && reverse_en_i &&
    line_rate_mode_i |-> colour_o == 2'h0)
    else $error("halt not on red");
  coef_block_a: assert property (ctrl_i == 8'h03 |=> !coef_write_ok_o)
    else $error("coef write open in scan");
endmodule
bind sltc_core sltc_core_checker u_chk (.clk_i, .reset_i, .ctrl_i,
  .addr_load_i, .addr_step_i, .addr_load_val_i, .addr_legal_max_i,
  .gain_coef_i, .line_rate_mode_i, .reverse_en_i,
  .line_end_o, .sensor_reset_pulse_o, .clamp_pulse_one_o,
  .clamp_pulse_two_o, .data_valid_o, .pixel_o, .dataport_addr_o,
  .fill_count_o, .colour_o, .halted_red_o, .refresh_en_o, .coef_write_ok_o);

// [verif/sltc_core_tb.sv]
// self-checking bench for the scan line timing core
`timescale 1ns/1ns
module sltc_core_tb;
  reg clk_i = 0, reset_i = 1, addr_load_i = 0, addr_step_i = 0;
  reg [7:0] ctrl_i = 8'h00;
  reg [5:0] mclk_code_i = 6'h0a;
  reg [13:0] addr_load_val_i = 14'h0000, addr_legal_max_i = 14'h0010;
  reg [13:0] level = 14'h1000;
  reg [15:0] gain_coef_i = 16'h4000;
  reg [7:0] f;
  // legal setup: divide product kept at six or more, phases 0..7, span 8
  reg line_rate_mode_i = 1'b1, dual_sample_mode_i = 1'b1;
  reg reverse_en_i = 1'b1, line_read_i = 1'b0;
  reg [3:0] horizontal_resolution_divider_i = 4'h1;
  reg [3:0] integration_time_stretch_i = 4'h0;
  reg [4:0] rst_on_i = 5'h01, rst_off_i = 5'h03;
  reg [4:0] cp1_on_i = 5'h02, cp1_off_i = 5'h04;
  reg [4:0] cp2_on_i = 5'h05, cp2_off_i = 5'h06;
  reg [4:0] ref_sample_i = 5'h02, sig_sample_i = 5'h05;
  reg [13:0] line_end_i = 14'h001e;
  reg [13:0] data_start_i = 14'h0002;
  reg [13:0] data_end_i = 14'h000a;
  reg [7:0] skip_steps_i = 8'h05;
  wire [13:0] pixel_i, pixel_o, dataport_addr_o, pixel_index_o;
  wire [7:0] fill_count_o, skip_left_o;
  wire core_tick_o, data_valid_o, refresh_en_o;
  wire pixel_tick_o, line_end_o, coef_write_ok_o;
  integer n_errors = 0, num_checks = 0, i, k, n;
  always #5 clk_i = ~clk_i;
  sltc_sensor_model u_sensor (.clk_i, .reset_i, .level_i(level),
    .pixel_o(pixel_i));
  sltc_core u_dut (.clk_i, .reset_i, .ctrl_i, .mclk_code_i,
    .line_rate_mode_i, .horizontal_resolution_divider_i,
    .integration_time_stretch_i, .dual_sample_mode_i,
    .rst_on_i, .rst_off_i, .cp1_on_i,
    .cp1_off_i, .cp2_on_i, .cp2_off_i,
    .ref_sample_i, .sig_sample_i,
    .line_end_i, .data_start_i,
    .data_end_i, .stored_phase_difference_i(14'h0000),
    .addr_load_val_i, .addr_load_i, .addr_step_i, .addr_legal_max_i,
    .pixel_i, .gain_coef_i, .scan_step_size_i(8'h04),
    .feed_step_size_i(8'h04), .skip_steps_i, .reverse_en_i,
    .line_read_i, .core_tick_o, .pixel_tick_o, .sensor_reset_pulse_o(),
    .clamp_pulse_one_o(), .clamp_pulse_two_o(), .ref_sample_o(),
    .sig_sample_o(), .line_end_o, .data_valid_o, .pixel_index_o,
    .pixel_o, .dataport_addr_o, .fill_count_o, .skip_left_o, .colour_o(),
    .halted_red_o(), .refresh_en_o, .coef_write_ok_o);
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task wait_valid;
    begin
      k = 0;
      @(negedge clk_i);
      while (data_valid_o !== 1'b1 && k < 6000) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (k >= 6000) begin
        chk("wait", 16'h0, 16'h1);
        end_sim;
      end
    end
  endtask
  task addr_op(input [13:0] v, input ld, input [13:0] e);
    begin
      addr_load_val_i = v;
      addr_load_i = ld;
      addr_step_i = !ld;
      @(negedge clk_i);
      addr_load_i = 0;
      addr_step_i = 0;
      // one idle edge so back-to-back calls never retoggle a strobe
      @(negedge clk_i);
      chk("addr", e, dataport_addr_o);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    reset_i = 0;
    for (i = 0; i < 4; i = i + 1) begin
      mclk_code_i = (i < 2) ? 6'h00 : (i == 2) ? 6'h02 : 6'h0a;
      horizontal_resolution_divider_i = (i < 2) ? 4'h6 :
        (i == 2) ? 4'h3 : 4'h1;
      line_rate_mode_i = (i != 0);
      repeat (12) @(negedge clk_i);
      k = 0;
      n = 0;
      repeat (480) begin
        @(negedge clk_i);
        k = k + core_tick_o;
        n = n + pixel_tick_o;
      end
      chk("ticks", 960 / (2 + mclk_code_i), k);
      chk("pixels", 960 / ((2 + mclk_code_i) *
        (line_rate_mode_i ? 8 : 24)), n);
    end
    addr_op(14'h0010, 1'b1, 14'h0010);
    addr_op(14'h0000, 1'b0, 14'h0000);
    addr_op(14'h0011, 1'b1, 14'h0011);
    addr_op(14'h0000, 1'b0, 14'h0012);
    // coefficients only change while idle, never mid-scan
    for (i = 0; i < 3; i = i + 1) begin
      ctrl_i = 8'h00;
      gain_coef_i = (i == 0) ? 16'h4000 : (i == 1) ? 16'h0000 :
        16'h8000;
      level = (i == 2) ? 14'h3000 : 14'h1000;
      repeat (2) @(negedge clk_i);
      chk("coefok", 16'h1, coef_write_ok_o);
      f = fill_count_o;
      ctrl_i = 8'h03;
      @(negedge clk_i);
      // a line end landing on the start edge still counts a line
      chk("fill", f + line_end_o, fill_count_o);
      chk("skip", 8'h04, skip_left_o);
      chk("coefok", 16'h0, coef_write_ok_o);
      wait_valid;
      wait_valid;
      chk("index", 16'h1, (pixel_index_o >= data_start_i) &&
        (pixel_index_o < data_end_i));
      chk("pixel", (i == 0) ? 14'h1000 : (i == 1) ? 14'h0 : 14'h3fff,
        pixel_o);
    end
    f = fill_count_o;
    line_read_i = 1'b1;
    @(negedge clk_i);
    line_read_i = 1'b0;
    chk("fillrd", f - 1'b1 + line_end_o, fill_count_o);
    ctrl_i = 8'h20;
    repeat (2) @(negedge clk_i);
    chk("refresh", 16'h0, refresh_en_o);
    chk("fill", 16'h0, fill_count_o);
    ctrl_i = 8'h00;
    end_sim;
  end
endmodule
